/* File: rtl/dsr_regs.svh */
// Summary of operation
// - First transaction locks link type until reset
// - Four-wire bytes shift LSB first, eight bits
// - Target byte 02h/03h selects group write
// - Target byte 82h/83h selects group read
// - Unknown target byte: rest of transfer ignored
// - Select low frames transfer; input only then
// - Host changes data falling; device samples rising
// - Data starts at given address, then increments
// - Only complete bytes are committed
// - Write shifts out old register contents
// - Read discards dummy bytes, returns registers
// - Frame settings apply N, integration N+1
// - Immediate settings apply when write completes
// - Hold bit defers frame updates until cleared
// - Two-wire bytes MSB first, then acknowledge
// - Two-wire slave address 0011010, direction bit
// - Two-wire message: 16-bit index, byte data
// - Start without stop is a repeated start
// - Write data acknowledged, index advances
// - Read acknowledged by host advances index
`ifndef DSR_REGS_SVH
`define DSR_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define DSR_HOLD_ADDR  16'h0104      // Frame update hold register index
`define DSR_HOLD_BIT   0             // Hold flag position
`define DSR_HOLD_RST   8'h01         // Hold register reset value
`define DSR_GRP_PAGE   7'h01         // Index bits [15:9] of groups 02h/03h

// ----------------------------------------------------------------
// Target select codes and slave address
// ----------------------------------------------------------------
`define DSR_TSEL_WR_LO 8'h02         // Write group 02h
`define DSR_TSEL_WR_HI 8'h03         // Write group 03h
`define DSR_TSEL_RD_LO 8'h82         // Read group 02h
`define DSR_TSEL_RD_HI 8'h83         // Read group 03h
`define DSR_SLV_ADDR   7'h1A         // Two-wire slave address

// ----------------------------------------------------------------
// Update classes (storage index = {group bit, address byte})
// ----------------------------------------------------------------
`define DSR_IMM_LO     9'h100        // First immediate register
`define DSR_IMM_HI     9'h10F        // Last immediate register
`define DSR_INT_LO     9'h020        // First integration time register
`define DSR_INT_HI     9'h022        // Last integration time register

`endif

/* File: rtl/dsr_pkg.sv */
// ----------------------------------------------------------------
// Types shared by the register port
// ----------------------------------------------------------------
package dsr_pkg;

  // Locked link decision
  typedef enum logic [1:0] {LNK_NONE, LNK_4W, LNK_2W} dsr_link_t;

  // Two-wire slave states
  typedef enum logic [2:0] {
    TW_IDLE, TW_ADDR, TW_AACK, TW_RX, TW_RACK, TW_TX, TW_TACK
  } dsr_tw_t;

  // State of the port except the register arrays
  typedef struct packed {
    dsr_link_t   link;     // Locked link type
    logic [3:0]  bits;     // Bit counter
    logic [7:0]  sr;       // Receive shifter
    logic [1:0]  nbyte;    // Byte position, saturates at 2
    logic [7:0]  tsel;     // Target select byte
    logic [7:0]  adr4;     // Four-wire register address
    logic [7:0]  osr;      // Four-wire output shifter
    logic        obit;     // Serial output bit
    dsr_tw_t     tw;       // Two-wire state
    logic        rw;       // Two-wire direction
    logic [15:0] idx;      // Two-wire register index
    logic [7:0]  tx;       // Two-wire transmit byte
    logic        oe;       // Data line pulled low
    logic [7:0]  hold;     // Frame update hold register
  } dsr_state_t;

endpackage

/* File: rtl/dsr_evt_if.sv */
// ----------------------------------------------------------------
// Synchronised pin levels and events
// ----------------------------------------------------------------
interface dsr_evt_if;
  logic sel_n;    // Select, synchronised
  logic din;      // Data line, synchronised
  logic clk_rise; // Serial clock rising edge pulse
  logic clk_fall; // Serial clock falling edge pulse
  logic start;    // Two-wire start pulse
  logic stop;     // Two-wire stop pulse
  logic vs_fall;  // Vertical sync falling edge pulse

  modport src (output sel_n, din, clk_rise, clk_fall, start, stop, vs_fall);
  modport snk (input  sel_n, din, clk_rise, clk_fall, start, stop, vs_fall);
endinterface

/* File: rtl/dsr_pin_sync.sv */
// ----------------------------------------------------------------
// Two-stage synchronisers and edge finding for the serial pins
// ----------------------------------------------------------------
module dsr_pin_sync (
  input  wire logic core_clk,         // Core clock
  input  wire logic rst_n,            // Async reset, active low
  input  wire logic serial_select_n,  // Select pin
  input  wire logic serial_clk,       // Serial clock pin
  input  wire logic serial_in_line,   // Data pin
  input  wire logic vertical_sync_n,  // Vertical sync pin
  dsr_evt_if.src    evt               // Events to the core
);

  // Stage 1, stage 2 and history for each of 4 pins
  logic [3:0] s1_ff;  // First stage, read only by stage 2
  logic [3:0] s2_ff;  // Synchronised levels
  logic [3:0] s3_ff;  // Previous synchronised levels

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 4'hF;
      s2_ff <= 4'hF;
      s3_ff <= 4'hF;
    end else begin
      s1_ff <= {vertical_sync_n, serial_in_line, serial_clk, serial_select_n};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // ----------------------------------------------------------------
  // Edge and condition decode
  // ----------------------------------------------------------------
  assign evt.sel_n    = s2_ff[0];
  assign evt.din      = s2_ff[2];
  assign evt.clk_rise = s2_ff[1] & ~s3_ff[1];
  assign evt.clk_fall = ~s2_ff[1] & s3_ff[1];
  // Data falls while clock high: start; data rises: stop
  assign evt.start    = s2_ff[1] & s3_ff[1] & s3_ff[2] & ~s2_ff[2];
  assign evt.stop     = s2_ff[1] & s3_ff[1] & ~s3_ff[2] & s2_ff[2];
  assign evt.vs_fall  = ~s2_ff[3] & s3_ff[3];

endmodule

/* File: rtl/dsr_port.sv */
`include "dsr_regs.svh"

// ----------------------------------------------------------------
// Dual serial register port: four-wire and two-wire access
// ----------------------------------------------------------------
module dsr_port (
  input  wire logic       core_clk,          // Core clock, 50 MHz
  input  wire logic       rst_n,             // Async reset, active low
  input  wire logic       serial_select_n,   // Four-wire select, active low
  input  wire logic       serial_clk,        // Serial clock from host
  input  wire logic       serial_in_line,    // Data in / two-wire data level
  output logic            serial_data_o,     // Two-wire data drive value
  output logic            serial_data_oe,    // Two-wire data drive enable
  output logic            serial_out_line,   // Four-wire data out
  input  wire logic       vertical_sync_n,   // Frame sync, active low
  input  wire logic [8:0] act_addr,          // Core read index of settings
  output logic      [7:0] act_data,          // Applied setting at act_addr
  output logic      [1:0] link_type,         // 0 none, 1 four-wire, 2 two-wire
  output logic            frame_update_hold  // Hold flag state
);

  localparam int DEPTH = 512;                                 // Two groups of 256
  localparam int INT_N = int'(`DSR_INT_HI - `DSR_INT_LO) + 1; // Staged registers

  dsr_evt_if evt ();                 // Pin events

  dsr_pkg::dsr_state_t st_ff;        // Registered state
  dsr_pkg::dsr_state_t nxt_st;       // Next state

  logic [7:0] mem_ff [DEPTH];        // Written values
  logic [7:0] act_ff [DEPTH];        // Applied values
  logic [7:0] stg_ff [INT_N];        // Integration staging

  logic       wr_en;                 // Register write strobe
  logic [8:0] wr_addr;               // Register write index
  logic [7:0] wr_data;               // Register write value
  logic       apply;                 // Copy written to applied
  logic [7:0] byte_4w;               // Completed four-wire byte
  logic [7:0] byte_2w;               // Completed two-wire byte
  logic       tsel_ok;               // Target byte valid

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  dsr_pin_sync u_sync (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .serial_select_n (serial_select_n),
    .serial_clk      (serial_clk),
    .serial_in_line  (serial_in_line),
    .vertical_sync_n (vertical_sync_n),
    .evt             (evt)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Immediate class membership
  function automatic logic is_imm(input logic [8:0] a);
    is_imm = (a >= `DSR_IMM_LO) && (a <= `DSR_IMM_HI);
  endfunction

  // Integration class membership
  function automatic logic is_int(input logic [8:0] a);
    is_int = (a >= `DSR_INT_LO) && (a <= `DSR_INT_HI);
  endfunction

  // Two-wire register read by 16-bit index
  function automatic logic [7:0] tw_read(input logic [15:0] i, input logic [7:0] h);
    if (i == `DSR_HOLD_ADDR) begin
      tw_read = h;
    end else if (i[15:9] == `DSR_GRP_PAGE) begin
      tw_read = mem_ff[i[8:0]];
    end else begin
      tw_read = 8'h00;
    end
  endfunction

  assign byte_4w = {evt.din, st_ff.sr[7:1]};
  assign byte_2w = {st_ff.sr[6:0], evt.din};
  assign tsel_ok = (st_ff.tsel == `DSR_TSEL_WR_LO) || (st_ff.tsel == `DSR_TSEL_WR_HI) ||
                   (st_ff.tsel == `DSR_TSEL_RD_LO) || (st_ff.tsel == `DSR_TSEL_RD_HI);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st  = st_ff;
    wr_en   = 1'b0;
    wr_addr = 9'h000;
    wr_data = 8'h00;
    // Link decision: first select low or start with select high
    if (st_ff.link == dsr_pkg::LNK_NONE) begin
      if (!evt.sel_n) begin
        nxt_st.link = dsr_pkg::LNK_4W;
      end else if (evt.start) begin
        nxt_st.link = dsr_pkg::LNK_2W;
        nxt_st.tw   = dsr_pkg::TW_ADDR;
        nxt_st.bits = 4'h0;
      end
    end else if (st_ff.link == dsr_pkg::LNK_4W) begin
      if (evt.sel_n) begin
        // Transfer ended: drop any partial byte
        nxt_st.bits  = 4'h0;
        nxt_st.nbyte = 2'd0;
        nxt_st.obit  = 1'b0;
      end else if (evt.clk_rise) begin
        nxt_st.sr   = byte_4w;
        nxt_st.osr  = {1'b0, st_ff.osr[7:1]};
        nxt_st.bits = st_ff.bits + 4'h1;
        if (st_ff.bits == 4'h7) begin
          nxt_st.bits = 4'h0;
          case (st_ff.nbyte)
            2'd0: begin
              // Target select byte
              nxt_st.tsel  = byte_4w;
              nxt_st.nbyte = 2'd1;
            end
            2'd1: begin
              // Start address; preload that register for output
              nxt_st.adr4  = byte_4w;
              nxt_st.osr   = mem_ff[{st_ff.tsel[0], byte_4w}];
              nxt_st.nbyte = 2'd2;
            end
            default: begin
              if (tsel_ok) begin
                // Write only for write codes; read dummies dropped
                if (!st_ff.tsel[7]) begin
                  wr_en   = 1'b1;
                  wr_addr = {st_ff.tsel[0], st_ff.adr4};
                  wr_data = byte_4w;
                end
                nxt_st.adr4 = st_ff.adr4 + 8'h01;
                nxt_st.osr  = mem_ff[{st_ff.tsel[0], st_ff.adr4 + 8'h01}];
              end else begin
                nxt_st.osr = 8'h00;
              end
            end
          endcase
        end
      end else if (evt.clk_fall) begin
        // Present next output bit, LSB first
        nxt_st.obit = (st_ff.nbyte == 2'd2) && tsel_ok && st_ff.osr[0];
      end
    end else begin
      // Two-wire slave; start always restarts address phase
      if (evt.start) begin
        nxt_st.tw   = dsr_pkg::TW_ADDR;
        nxt_st.bits = 4'h0;
        nxt_st.oe   = 1'b0;
      end else if (evt.stop) begin
        nxt_st.tw = dsr_pkg::TW_IDLE;
        nxt_st.oe = 1'b0;
      end else begin
        case (st_ff.tw)
          dsr_pkg::TW_IDLE: begin
            nxt_st.oe = 1'b0;
          end
          dsr_pkg::TW_ADDR, dsr_pkg::TW_RX: begin
            if (evt.clk_rise && st_ff.bits != 4'h8) begin
              nxt_st.sr   = byte_2w;
              nxt_st.bits = st_ff.bits + 4'h1;
            end else if (evt.clk_fall && st_ff.bits == 4'h8) begin
              nxt_st.bits = 4'h0;
              if (st_ff.tw == dsr_pkg::TW_ADDR) begin
                if (st_ff.sr[7:1] == `DSR_SLV_ADDR) begin
                  nxt_st.oe    = 1'b1;
                  nxt_st.rw    = st_ff.sr[0];
                  nxt_st.nbyte = 2'd0;
                  nxt_st.tw    = dsr_pkg::TW_AACK;
                end else begin
                  nxt_st.tw = dsr_pkg::TW_IDLE;
                end
              end else begin
                nxt_st.oe = 1'b1;
                nxt_st.tw = dsr_pkg::TW_RACK;
                case (st_ff.nbyte)
                  2'd0: begin
                    nxt_st.idx[15:8] = st_ff.sr;
                    nxt_st.nbyte     = 2'd1;
                  end
                  2'd1: begin
                    nxt_st.idx[7:0] = st_ff.sr;
                    nxt_st.nbyte    = 2'd2;
                  end
                  default: begin
                    // Store and advance with the acknowledge
                    if (st_ff.idx == `DSR_HOLD_ADDR) begin
                      nxt_st.hold = st_ff.sr;
                    end else if (st_ff.idx[15:9] == `DSR_GRP_PAGE) begin
                      wr_en   = 1'b1;
                      wr_addr = st_ff.idx[8:0];
                      wr_data = st_ff.sr;
                    end
                    nxt_st.idx = st_ff.idx + 16'h0001;
                  end
                endcase
              end
            end
          end
          dsr_pkg::TW_AACK: begin
            if (evt.clk_fall) begin
              if (st_ff.rw) begin
                nxt_st.tx = tw_read(st_ff.idx, st_ff.hold);
                nxt_st.oe = ~tw_read(st_ff.idx, st_ff.hold) >> 7 == 8'h01;
                nxt_st.tw = dsr_pkg::TW_TX;
              end else begin
                nxt_st.oe = 1'b0;
                nxt_st.tw = dsr_pkg::TW_RX;
              end
            end
          end
          dsr_pkg::TW_RACK: begin
            if (evt.clk_fall) begin
              nxt_st.oe = 1'b0;
              nxt_st.tw = dsr_pkg::TW_RX;
            end
          end
          dsr_pkg::TW_TX: begin
            if (evt.clk_rise) begin
              nxt_st.bits = st_ff.bits + 4'h1;
              nxt_st.tx   = {st_ff.tx[6:0], 1'b0};
            end else if (evt.clk_fall) begin
              if (st_ff.bits == 4'h8) begin
                nxt_st.oe   = 1'b0;
                nxt_st.bits = 4'h0;
                nxt_st.tw   = dsr_pkg::TW_TACK;
              end else begin
                nxt_st.oe = ~st_ff.tx[7];
              end
            end
          end
          dsr_pkg::TW_TACK: begin
            // Host answer: index advances on either answer
            if (evt.clk_rise) begin
              nxt_st.idx = st_ff.idx + 16'h0001;
              nxt_st.rw  = ~evt.din;
            end else if (evt.clk_fall) begin
              if (st_ff.rw) begin
                nxt_st.tx = tw_read(st_ff.idx, st_ff.hold);
                nxt_st.oe = ~tw_read(st_ff.idx, st_ff.hold) >> 7 == 8'h01;
                nxt_st.tw = dsr_pkg::TW_TX;
              end else begin
                nxt_st.tw = dsr_pkg::TW_IDLE;
              end
            end
          end
          default: begin
            nxt_st.tw = dsr_pkg::TW_IDLE;
          end
        endcase
      end
    end
  end

  // Settings follow the frame when not held, all at once on release
  assign apply = (evt.vs_fall && !st_ff.hold[`DSR_HOLD_BIT]) ||
                 (st_ff.hold[`DSR_HOLD_BIT] && !nxt_st.hold[`DSR_HOLD_BIT]);

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff      <= '0;
      st_ff.hold <= `DSR_HOLD_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Register storage, staging and application
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= 8'h00;
        act_ff[i] <= 8'h00;
      end
      for (int j = 0; j < INT_N; j++) begin
        stg_ff[j] <= 8'h00;
      end
    end else begin
      // Integration settings reach output one frame later
      if (evt.vs_fall) begin
        for (int j = 0; j < INT_N; j++) begin
          act_ff[9'(j) + `DSR_INT_LO] <= stg_ff[j];
        end
      end
      if (apply) begin
        for (int i = 0; i < DEPTH; i++) begin
          if (is_int(9'(i))) begin
            stg_ff[i - int'(`DSR_INT_LO)] <= mem_ff[i];
          end else if (!is_imm(9'(i))) begin
            act_ff[i] <= mem_ff[i];
          end
        end
      end
      if (wr_en) begin
        mem_ff[wr_addr] <= wr_data;
        if (is_imm(wr_addr)) begin
          act_ff[wr_addr] <= wr_data;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign serial_data_o     = 1'b0;
  assign serial_data_oe    = st_ff.oe;
  assign serial_out_line   = st_ff.obit;
  assign act_data          = act_ff[act_addr];
  assign link_type         = st_ff.link;
  assign frame_update_hold = st_ff.hold[`DSR_HOLD_BIT];

endmodule

/* File: test/dsr_port_sva.sv */
// ------------------------------------------------
// Port checker
// ------------------------------------------------
module dsr_port_sva (
  input wire logic       core_clk,          // Core clock
  input wire logic       rst_n,             // Reset, active low
  input wire logic       serial_select_n,   // Select pin
  input wire logic       serial_data_o,     // Data drive value
  input wire logic       serial_data_oe,    // Data drive enable
  input wire logic       serial_out_line,   // Four-wire reply
  input wire logic [1:0] link_type,         // Locked link
  input wire logic       frame_update_hold  // Hold flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Select settled high or low long enough to pass the synchronisers
  sequence sel_idle;
    serial_select_n[*6];
  endsequence
  sequence sel_held_low;
    !serial_select_n[*6];
  endsequence
  chk_out_idle: assert property (sel_idle |-> !serial_out_line)
    else $error("reply line active while deselected");
  chk_link_first: assert property (
    (link_type == 2'h0) ##1 sel_held_low |=> link_type == 2'h1)
    else $error("select low did not lock four-wire");
  chk_link_lock: assert property (link_type != 2'h0 |=> $stable(link_type))
    else $error("link type changed before reset");
  chk_link_reset: assert property (
    $rose(rst_n) |-> link_type == 2'h0 && frame_update_hold)
    else $error("link or hold not at reset value");
  chk_no_ack_4w: assert property (link_type == 2'h1 |-> !serial_data_oe)
    else $error("data line pulled in four-wire mode");
  chk_oe_two_wire: assert property (serial_data_oe |-> link_type == 2'h2)
    else $error("data line pulled outside two-wire mode");
  chk_ack_hold: assert property ($rose(serial_data_oe) |-> serial_data_oe[*4])
    else $error("acknowledge drive too short");
  chk_drive_low: assert property (serial_data_oe |-> !serial_data_o)
    else $error("data line driven high");
endmodule

bind dsr_port dsr_port_sva dsr_port_sva_inst (.core_clk(core_clk), .rst_n(rst_n),
  .serial_select_n(serial_select_n), .serial_data_o(serial_data_o),
  .serial_data_oe(serial_data_oe), .serial_out_line(serial_out_line),
  .link_type(link_type), .frame_update_hold(frame_update_hold));

/* File: test/dsr_host.sv */
// ------------------------------------------------
// Host master model, both link kinds
// ------------------------------------------------
module dsr_host (
  input  wire logic core_clk,         // Pacing clock
  input  wire logic serial_data_oe,   // Device pulls data low
  input  wire logic serial_out_line,  // Four-wire reply
  output logic      serial_select_n,  // Select, active low
  output logic      serial_clk,       // Serial clock
  output logic      serial_in_line    // Resolved data wire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda = 1'b1;  // Host data, high when released
  logic sel = 1'b1;  // Select held high for two-wire use
  logic sck = 1'b1;  // Clock stands high between frames
  assign serial_select_n = sel;
  assign serial_clk      = sck;
  // Pull-up wire: low if either party pulls it
  assign serial_in_line  = sda & ~serial_data_oe;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Four-wire unit: LSB first, data changed together with the falling clock edge
  task automatic byte4(input logic [7:0] b, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < n; i++) begin
      sck <= 1'b0;
      sda <= b[i];
      tick(4);
      sck <= 1'b1;
      r[i] = serial_out_line;
      tick(4);
    end
  endtask
  // Select low, target, address, two data units (second may be partial)
  task automatic xfer4(input logic [7:0] target_select_byte, adr, d0, d1, input int n1,
                       output logic [7:0] o0, o1);
    logic [7:0] unused;
    sel <= 1'b0;
    tick(4);
    byte4(target_select_byte, 8, unused);
    byte4(adr, 8, unused);
    byte4(d0, 8, o0);
    byte4(d1, n1, o1);
    sel <= 1'b1;
    tick(8);
  endtask
  // Start, also a repeated start when no stop came first
  task automatic start2;
    sda <= 1'b1;
    tick(2);
    sck <= 1'b1;
    tick(4);
    sda <= 1'b0;
    tick(4);
  endtask
  task automatic stop2;
    sda <= 1'b0;
    tick(2);
    sck <= 1'b1;
    tick(4);
    sda <= 1'b1;
    tick(4);
  endtask
  // Two-wire unit: MSB first, then the device's acknowledge
  task automatic byte2(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      tick(2);
      sda <= b[i];
      tick(2);
      sck <= 1'b1;
      tick(4);
    end
    sck <= 1'b0;
    tick(2);
    sda <= 1'b1;
    tick(2);
    sck <= 1'b1;
    tick(2);
    a = serial_data_oe;
    tick(2);
    sck <= 1'b0;
    tick(4);
  endtask
endmodule

/* File: test/dsr_port_test.sv */
module dsr_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk        = 1'b0;    // Core clock
  logic       rst_n           = 1'b0;    // Reset, active low
  logic       vertical_sync_n = 1'b1;    // Frame sync
  logic [8:0] act_addr        = 9'h000;  // Applied setting index
  logic       serial_select_n, serial_clk, serial_in_line;
  logic       serial_data_o, serial_data_oe, serial_out_line, frame_update_hold, a;
  logic [7:0] act_data, o0, o1;
  logic [1:0] link_type;
  int         fails = 0;
  int         check_count = 0;
  always #10 core_clk = ~core_clk;
  dsr_port dsr_port_inst (.core_clk(core_clk), .rst_n(rst_n),
    .serial_select_n(serial_select_n), .serial_clk(serial_clk),
    .serial_in_line(serial_in_line), .serial_data_o(serial_data_o),
    .serial_data_oe(serial_data_oe), .serial_out_line(serial_out_line),
    .vertical_sync_n(vertical_sync_n), .act_addr(act_addr), .act_data(act_data),
    .link_type(link_type), .frame_update_hold(frame_update_hold));
  dsr_host dsr_host_inst (.core_clk(core_clk), .serial_data_oe(serial_data_oe),
    .serial_out_line(serial_out_line), .serial_select_n(serial_select_n),
    .serial_clk(serial_clk), .serial_in_line(serial_in_line));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Four-wire writes, old-value reply, partial unit, unknown target
  task automatic t_four_wire;
    dsr_host_inst.xfer4(8'h02, 8'h10, 8'hA5, 8'h3C, 8, o0, o1);
    check(8'(link_type), 8'h01);
    dsr_host_inst.xfer4(8'h02, 8'h10, 8'h77, 8'h11, 4, o0, o1);
    check(o0, 8'hA5);
    dsr_host_inst.xfer4(8'h05, 8'h10, 8'h11, 8'h22, 8, o0, o1);
    check(o0, 8'h00);
    dsr_host_inst.xfer4(8'h82, 8'h10, 8'h00, 8'h00, 8, o0, o1);
    check(o0, 8'h77);
    check(o1, 8'h3C);
  endtask
  // Second group, immediate class, held frame class
  task automatic t_group_hold;
    dsr_host_inst.xfer4(8'h03, 8'h00, 8'h5A, 8'h00, 0, o0, o1);
    act_addr <= 9'h100;
    repeat (2) @(posedge core_clk);
    check(act_data, 8'h5A);
    dsr_host_inst.xfer4(8'h83, 8'h00, 8'h00, 8'h00, 0, o0, o1);
    check(o0, 8'h5A);
    act_addr        <= 9'h010;
    vertical_sync_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    vertical_sync_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    check(act_data, 8'h00);
  endtask
  // Two-wire: refused while locked, then after a new reset
  task automatic t_two_wire;
    dsr_host_inst.start2();
    dsr_host_inst.byte2(8'h34, a);
    dsr_host_inst.stop2();
    check(8'(a), 8'h00);
    rst_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(8'(link_type), 8'h00);
    dsr_host_inst.start2();
    dsr_host_inst.byte2(8'h36, a);
    check(8'(a), 8'h00);
    dsr_host_inst.start2();
    dsr_host_inst.byte2(8'h34, a);
    check(8'(a), 8'h01);
    check(8'(link_type), 8'h02);
    dsr_host_inst.byte2(8'h01, a);
    dsr_host_inst.byte2(8'h04, a);
    dsr_host_inst.byte2(8'h00, a);
    check(8'(a), 8'h01);
    dsr_host_inst.stop2();
    check(8'(frame_update_hold), 8'h00);
    // Frame setting written just after a frame start, seen at the next one
    vertical_sync_n <= 1'b0;
    act_addr        <= 9'h010;
    dsr_host_inst.start2();
    dsr_host_inst.byte2(8'h34, a);
    dsr_host_inst.byte2(8'h02, a);
    dsr_host_inst.byte2(8'h10, a);
    dsr_host_inst.byte2(8'h6B, a);
    dsr_host_inst.stop2();
    vertical_sync_n <= 1'b1;
    check(act_data, 8'h00);
    repeat (4) @(posedge core_clk);
    vertical_sync_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    check(act_data, 8'h6B);
    vertical_sync_n <= 1'b1;
  endtask
  initial begin
    #400us;
    fails++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(8'(link_type), 8'h00);
    check(8'(frame_update_hold), 8'h01);
    t_four_wire();
    t_group_hold();
    t_two_wire();
    complete_run();
  end
endmodule
